// file: testbench/fast_gpio_port_with_edge_wake_tb_top.sv
// Self-checking bench for the fast I/O port block.
// Assumes the checker is bound in and the board model sits on the pins.
`timescale 1ns/100ps
`include "gpio_defines.vh"
module fast_gpio_port_with_edge_wake_tb_top;
   reg mclk = 1'b0;
   reg run = 1'b1;
   reg rst_b = 1'b1;
   reg ce = 1'b1;
   reg lb_sel = 1'b0;
   reg leg_sel = 1'b0;
   reg wr = 1'b0;
   reg edg = 1'b0;
   reg [2:0] port = 3'h0;
   reg [2:0] idx = 3'h0;
   reg [3:0] be = 4'h0;
   reg [31:0] wd = 32'h0;
   reg [31:0] rd;
   reg [63:0] analog_sel = 64'h8;
   reg [159:0] ext_drv = {95'h0, 1'b1, 60'h0, 4'hf};
   reg [159:0] ext_lvl = {156'h0, 4'h6};
   wire [31:0] lb_rdata, leg_rdata;
   wire [159:0] pin_in, pin_out, pin_oe;
   wire lb_ack, leg_ack, edge_irq, wake;
   integer n_errors = 0;
   integer checked = 0;
   always #5 mclk = run ? ~mclk : mclk;
   gpio_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv),
      .ext_lvl(ext_lvl), .pin_in(pin_in));
   gpio_port DUT (.mclk(mclk), .rst_b(rst_b), .ce(ce), .lb_sel(lb_sel), .lb_wr(wr),
      .lb_port(port), .lb_edge(edg), .lb_idx(idx), .lb_be(be), .lb_wdata(wd),
      .lb_rdata(lb_rdata), .lb_ack(lb_ack), .leg_sel(leg_sel), .leg_wr(wr),
      .leg_port(port[0]), .leg_idx(idx), .leg_be(be), .leg_wdata(wd), .leg_rdata(leg_rdata),
      .leg_ack(leg_ack), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .analog_sel(analog_sel), .edge_irq(edge_irq), .wake(wake));
   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task acc(input l, input w, input [2:0] p, input e, input [2:0] i, input [3:0] b,
      input [31:0] d);
      begin
         @(posedge mclk);
         #1 {lb_sel, leg_sel, wr, port, edg, idx, be, wd} = {!l, l, w, p, e, i, b, d};
         @(posedge mclk);
         #1 {lb_sel, leg_sel} = 2'b00;
         chk("ack", 32'h1, {31'h0, l ? leg_ack : lb_ack});
         rd = l ? leg_rdata : lb_rdata;
      end
   endtask
   task t_reset;
      begin
         chk("oe_any", 32'h0, {31'h0, |pin_oe});
         acc(0, 0, 3, 0, `GPIO_IDX_DIR, 4'hf, 0);
         chk("dir3", 32'h0, rd);
      end
   endtask
   task t_dir_set_clr;
      begin
         acc(0, 1, 1, 0, `GPIO_IDX_DIR, 4'hf, 32'hff);
         acc(0, 1, 1, 0, `GPIO_IDX_SET, 4'hf, 32'ha5);
         acc(0, 1, 1, 0, `GPIO_IDX_CLR, 4'hf, 32'h21);
         acc(0, 1, 1, 0, `GPIO_IDX_SET, 4'hf, 32'h0);
         @(posedge mclk);
         #1 chk("oe1", 32'hff, pin_oe[63:32]);
         chk("out1", 32'h84, pin_out[63:32]);
         repeat (3) @(posedge mclk);
         acc(0, 0, 1, 0, `GPIO_IDX_PIN, 4'hf, 0);
         chk("pin1", 32'hffffff84, rd);
         acc(0, 0, 1, 0, `GPIO_IDX_SET, 4'hf, 0);
         chk("latch1", 32'h84, rd);
      end
   endtask
   task t_mask_lanes;
      begin
         acc(0, 1, 1, 0, `GPIO_IDX_MASK, 4'hf, 32'hf);
         acc(0, 1, 1, 0, `GPIO_IDX_OUT, 4'h1, 32'hffffffff);
         acc(0, 0, 1, 0, `GPIO_IDX_OUT, 4'hf, 0);
         chk("out_byte", 32'hf0, rd);
         acc(0, 1, 1, 0, `GPIO_IDX_OUT, 4'h3, 32'h12345678);
         acc(0, 0, 1, 0, `GPIO_IDX_OUT, 4'hf, 0);
         chk("out_half", 32'h5670, rd);
         acc(0, 1, 1, 0, `GPIO_IDX_MASK, 4'hf, 0);
         acc(0, 1, 1, 0, `GPIO_IDX_OUT, 4'hf, 32'hdeadbeef);
         @(posedge mclk);
         #1 chk("out_word", 32'hdeadbeef, pin_out[63:32]);
         acc(1, 0, 1, 0, `GPIO_IDX_OUT, 4'hf, 0);
         chk("leg_out1", 32'hdeadbeef, rd);
         acc(1, 1, 0, 0, `GPIO_IDX_DIR, 4'hf, 32'h80000000);
         acc(0, 0, 0, 0, `GPIO_IDX_DIR, 4'hf, 0);
         chk("dir0", 32'h80000000, rd);
      end
   endtask
   task t_edges;
      begin
         acc(0, 1, 0, 1, `GPIO_IDX_RISE_EN, 4'hf, 32'hd);
         acc(0, 1, 0, 1, `GPIO_IDX_FALL_EN, 4'hf, 32'he);
         ext_lvl[3:0] = 4'h9;
         repeat (6) @(posedge mclk);
         #1 ext_lvl[3:0] = 4'hd;
         repeat (6) @(posedge mclk);
         #1 chk("irq", 32'h1, {31'h0, edge_irq & wake});
         acc(0, 0, 0, 1, `GPIO_IDX_RISE_ST, 4'hf, 0);
         chk("rise_st", 32'h5, rd);
         acc(0, 0, 0, 1, `GPIO_IDX_FALL_ST, 4'hf, 0);
         chk("fall_st", 32'h6, rd);
         acc(0, 1, 0, 1, `GPIO_IDX_RISE_EN, 4'hf, 0);
         acc(0, 1, 0, 1, `GPIO_IDX_INT_CLR, 4'hf, 32'hf);
         repeat (6) @(posedge mclk);
         #1 chk("irq_clr", 32'h0, {31'h0, edge_irq | wake});
         acc(0, 1, 2, 1, `GPIO_IDX_RISE_EN, 4'hf, 32'h1);
         @(posedge mclk);
         #1 run = 1'b0;
         #50 ext_lvl[64] = 1'b1;
         #1 chk("wake_stop", 32'h1, {31'h0, wake});
         #49 run = 1'b1;
         repeat (6) @(posedge mclk);
         #1 chk("wake", 32'h1, {31'h0, wake});
         acc(0, 0, 2, 1, `GPIO_IDX_RISE_ST, 4'hf, 0);
         chk("rise_st2", 32'h1, rd);
      end
   endtask
   task t_hold;
      begin
         @(posedge mclk);
         #1 ce = 1'b0;
         {lb_sel, wr, port, edg, idx, be, wd} = {1'b1, 1'b1, 3'h1, 1'b0, `GPIO_IDX_OUT, 4'hf,
            32'h0};
         @(posedge mclk);
         #1 lb_sel = 1'b0;
         chk("ack_hold", 32'h0, {31'h0, lb_ack});
         ce = 1'b1;
         acc(0, 0, 1, 0, `GPIO_IDX_OUT, 4'hf, 0);
         chk("out_hold", 32'hdeadbeef, rd);
      end
   endtask
   task tally_and_finish;
      begin
         $display("Mismatches %0d of %0d checks", n_errors, checked);
         if (n_errors == 0 && checked > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      #100000 n_errors = n_errors + 1;
      tally_and_finish;
   end
   initial begin
      #1 rst_b = 1'b0;
      repeat (5) @(posedge mclk);
      #1 rst_b = 1'b1;
      t_reset;
      t_dir_set_clr;
      t_mask_lanes;
      t_hold;
      t_edges;
      tally_and_finish;
   end
endmodule

// file: testbench/gpio_board_model.sv
// Board around the port pins: pull-ups, plus lines the bench drives.
// Assumes an enable of 1 means the port drives the pin.
`timescale 1ns/100ps
module gpio_board_model (
   input wire [159:0] pin_out,
   input wire [159:0] pin_oe,
   input wire [159:0] ext_drv,
   input wire [159:0] ext_lvl,
   output wire [159:0] pin_in
);
   // Undriven lines float up to the pull-up level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_lvl) | (~pin_oe & ~ext_drv);
endmodule

// file: testbench/gpio_port_asserts.sv
// Port-level checker for the fast I/O port block.
// Assumes one clock mclk and an async active-low rst_b.
`timescale 1ns/100ps
`include "gpio_defines.vh"
module gpio_port_asserts (
   input wire mclk,
   input wire rst_b,
   input wire ce,
   input wire lb_sel,
   input wire lb_wr,
   input wire lb_edge,
   input wire [2:0] lb_idx,
   input wire [31:0] lb_wdata,
   input wire lb_ack,
   input wire leg_sel,
   input wire leg_wr,
   input wire leg_ack,
   input wire [159:0] pin_out,
   input wire [159:0] pin_oe,
   input wire edge_irq,
   input wire wake
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   sequence zero_set;
      ce && lb_sel && lb_wr && !lb_edge && lb_idx == `GPIO_IDX_SET && lb_wdata == 32'h0;
   endsequence
   sequence quiet;
      !lb_sel && !leg_sel;
   endsequence
   a_ack_after_sel: assert property (ce && lb_sel |=> lb_ack)
      else $error("lb_ack missing after access");
   a_ack_when_idle: assert property (ce && !lb_sel |=> !lb_ack)
      else $error("lb_ack without access");
   a_leg_ack_seen: assert property (ce && leg_sel && !lb_sel |=> leg_ack)
      else $error("leg_ack missing after access");
   a_reset_inputs: assert property (disable iff (1'b0) !rst_b |-> pin_oe == 160'h0)
      else $error("pin driven during reset");
   a_out_cause: assert property ($changed(pin_out) |-> $past(lb_sel && lb_wr || leg_sel && leg_wr, 2))
      else $error("pin_out changed without write");
   a_dir_cause: assert property ($changed(pin_oe) |-> $past(lb_sel && lb_wr || leg_sel && leg_wr, 2))
      else $error("pin_oe changed without write");
   a_zero_set_noop: assert property (zero_set |=> ##1 $stable(pin_out))
      else $error("zero set write changed pins");
   a_wake_irq: assert property ($rose(wake) ##0 quiet [*4] |-> edge_irq)
      else $error("edge_irq missing after wake");
endmodule
bind gpio_port gpio_port_asserts chk (.mclk, .rst_b, .ce, .lb_sel, .lb_wr, .lb_edge, .lb_idx,
   .lb_wdata, .lb_ack, .leg_sel, .leg_wr, .leg_ack, .pin_out, .pin_oe, .edge_irq, .wake);

// file: verilog/gpio_defines.vh
// Constants for the fast general purpose I/O port block.
// Assumes the includer works in plain Verilog-2005.
`ifndef GPIO_DEFINES_VH
`define GPIO_DEFINES_VH
// --------------------------------------------------------------
// Register word indices on the local bus
// --------------------------------------------------------------
`define GPIO_IDX_DIR 3'h0
`define GPIO_IDX_MASK 3'h1
`define GPIO_IDX_PIN 3'h2
`define GPIO_IDX_SET 3'h3
`define GPIO_IDX_CLR 3'h4
`define GPIO_IDX_OUT 3'h5
// --------------------------------------------------------------
// Edge interrupt register indices (ports 0 and 2 only)
// --------------------------------------------------------------
`define GPIO_IDX_RISE_EN 3'h0
`define GPIO_IDX_FALL_EN 3'h1
`define GPIO_IDX_RISE_ST 3'h2
`define GPIO_IDX_FALL_ST 3'h3
`define GPIO_IDX_INT_CLR 3'h4
// --------------------------------------------------------------
// Widths and reset values
// --------------------------------------------------------------
`define GPIO_WIDTH 32
`define GPIO_NPORT 5
`define GPIO_DIR_RST 32'h00000000
`define GPIO_OUT_RST 32'h00000000
`define GPIO_MASK_RST 32'h00000000
`endif

// file: verilog/gpio_edge_cell.v
// Asynchronous rising and falling edge catcher for one port of pins.
// Assumes pins may toggle with every clock stopped; clears come from mclk.
`timescale 1ns/100ps
module gpio_edge_cell (
   input wire [31:0] pin,
   input wire [31:0] rise_en,
   input wire [31:0] fall_en,
   input wire [31:0] clr,
   input wire rst_b,
   output wire [31:0] rise_st,
   output wire [31:0] fall_st
);
   genvar i;
   generate
      for (i = 0; i < 32; i = i + 1) begin : bit_g
         reg r;
         reg f;
         // --------------------------------------------------------------
         // Pin edge itself is the clock, so no clock is needed to catch it
         // --------------------------------------------------------------
         always @(posedge pin[i] or negedge rst_b or posedge clr[i]) begin
            if (!rst_b)
               r <= 1'b0;
            else if (clr[i] && !(pin[i] && rise_en[i]))
               r <= 1'b0;
            else if (rise_en[i])
               r <= 1'b1;
         end
         always @(negedge pin[i] or negedge rst_b or posedge clr[i]) begin
            if (!rst_b)
               f <= 1'b0;
            else if (clr[i])
               f <= 1'b0;
            else if (fall_en[i])
               f <= 1'b1;
         end
         assign rise_st[i] = r;
         assign fall_st[i] = f;
      end
   endgenerate
endmodule

// file: verilog/gpio_port.v
// Fast general purpose I/O block: five 32-bit ports on a local bus,
// with edge wake interrupts on ports 0 and 2.
// Assumes a single-cycle local bus master on mclk and external pins.
`timescale 1ns/100ps
`include "gpio_defines.vh"
module gpio_port (
   input wire mclk,
   input wire rst_b,
   input wire ce,
   // Local bus: one-cycle access, read data next cycle
   input wire lb_sel,
   input wire lb_wr,
   input wire [2:0] lb_port,
   input wire lb_edge,
   input wire [2:0] lb_idx,
   input wire [3:0] lb_be,
   input wire [31:0] lb_wdata,
   output reg [31:0] lb_rdata,
   output reg lb_ack,
   // Legacy peripheral-bus window, ports 0 and 1 only
   input wire leg_sel,
   input wire leg_wr,
   input wire leg_port,
   input wire [2:0] leg_idx,
   input wire [3:0] leg_be,
   input wire [31:0] leg_wdata,
   output reg [31:0] leg_rdata,
   output reg leg_ack,
   // Pins
   input wire [159:0] pin_in,
   output reg [159:0] pin_out,
   output reg [159:0] pin_oe,
   input wire [63:0] analog_sel,
   output reg edge_irq,
   output reg wake
);
   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   function [31:0] lanes;
      input [3:0] be;
      begin
         lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [31:0] en;
      begin
         merge = (old & ~en) | (wd & en);
      end
   endfunction

   // --------------------------------------------------------------
   // Storage
   // --------------------------------------------------------------
   reg [31:0] dir [0:4];
   reg [31:0] outl [0:4];
   reg [31:0] mask [0:4];
   reg [31:0] rise_en [0:1];
   reg [31:0] fall_en [0:1];
   reg [31:0] int_clr [0:1];
   reg [159:0] pin_s1;
   reg [159:0] pin_s2;
   wire [31:0] rise_st [0:1];
   wire [31:0] fall_st [0:1];
   wire [31:0] ep0 = pin_in[31:0] & ~analog_sel[31:0];
   wire [31:0] ep2 = pin_in[95:64] & ~analog_sel[63:32];

   // --------------------------------------------------------------
   // Edge catchers on ports 0 and 2
   // --------------------------------------------------------------
   gpio_edge_cell edge0 (
      .pin(ep0),
      .rise_en(rise_en[0] & ~analog_sel[31:0]),
      .fall_en(fall_en[0] & ~analog_sel[31:0]),
      .clr(int_clr[0]),
      .rst_b(rst_b),
      .rise_st(rise_st[0]),
      .fall_st(fall_st[0])
   );

   gpio_edge_cell edge2 (
      .pin(ep2),
      .rise_en(rise_en[1] & ~analog_sel[63:32]),
      .fall_en(fall_en[1] & ~analog_sel[63:32]),
      .clr(int_clr[1]),
      .rst_b(rst_b),
      .rise_st(rise_st[1]),
      .fall_st(fall_st[1])
   );

   // Status crossing from the asynchronous catchers into mclk
   reg [127:0] st_s1;
   reg [127:0] st_s2;
   wire [127:0] st_raw = {fall_st[1], rise_st[1], fall_st[0], rise_st[0]};

   // --------------------------------------------------------------
   // Access decode, local bus wins over the legacy window
   // --------------------------------------------------------------
   reg acc;
   reg acc_wr;
   reg acc_edge;
   reg [2:0] acc_port;
   reg [2:0] acc_idx;
   reg [31:0] acc_en;
   reg [31:0] acc_wd;
   always @* begin
      acc = 1'b0;
      acc_wr = 1'b0;
      acc_edge = 1'b0;
      acc_port = 3'h0;
      acc_idx = 3'h0;
      acc_en = 32'h00000000;
      acc_wd = 32'h00000000;
      // The legacy window has no edge group and reaches ports 0 and 1 only
      if (lb_sel) begin
         acc = 1'b1;
         acc_wr = lb_wr;
         acc_edge = lb_edge;
         acc_port = lb_port;
         acc_idx = lb_idx;
         acc_en = lanes(lb_be);
         acc_wd = lb_wdata;
      end else if (leg_sel) begin
         acc = 1'b1;
         acc_wr = leg_wr;
         acc_port = {2'b00, leg_port};
         acc_idx = leg_idx;
         acc_en = lanes(leg_be);
         acc_wd = leg_wdata;
      end
   end

   // Edge registers exist for ports 0 and 2 only; port bit 1 picks the pair
   wire [0:0] eport = acc_port[1];
   wire edge_ok = acc_edge && (acc_port == 3'h0 || acc_port == 3'h2);
   wire port_ok = !acc_edge && (acc_port < 3'h5);

   // --------------------------------------------------------------
   // Read data
   // --------------------------------------------------------------
   reg [31:0] rd;
   reg [31:0] live;
   reg [31:0] st_rd;
   always @* begin
      rd = 32'h00000000;
      live = 32'h00000000;
      st_rd = 32'h00000000;
      if (port_ok) begin
         live = pin_s2[acc_port*32 +: 32];
         // PIN reads the synchronised pins, SET and OUT read the latch
         case (acc_idx)
            `GPIO_IDX_DIR: rd = dir[acc_port];
            `GPIO_IDX_MASK: rd = mask[acc_port];
            `GPIO_IDX_PIN: rd = live & ~mask[acc_port];
            `GPIO_IDX_SET: rd = outl[acc_port] & ~mask[acc_port];
            `GPIO_IDX_OUT: rd = outl[acc_port] & ~mask[acc_port];
            default: rd = 32'h00000000;
         endcase
      end else if (edge_ok) begin
         // Rising status is the low word of each port's pair, falling the high
         if (acc_idx == `GPIO_IDX_FALL_ST)
            st_rd = st_s2[eport*64 + 32 +: 32];
         else
            st_rd = st_s2[eport*64 +: 32];
         case (acc_idx)
            `GPIO_IDX_RISE_EN: rd = rise_en[eport];
            `GPIO_IDX_FALL_EN: rd = fall_en[eport];
            `GPIO_IDX_RISE_ST: rd = st_rd;
            `GPIO_IDX_FALL_ST: rd = st_rd;
            default: rd = 32'h00000000;
         endcase
      end
      rd = rd & acc_en;
   end

   // --------------------------------------------------------------
   // Register writes and outputs
   // --------------------------------------------------------------
   // Masked bits are shielded from PIN, SET, CLR and OUT writes
   integer p;
   reg [31:0] wen;
   always @* begin
      wen = 32'h00000000;
      if (port_ok)
         wen = acc_en & ~mask[acc_port];
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (p = 0; p < 5; p = p + 1) begin
            dir[p] <= `GPIO_DIR_RST;
            outl[p] <= `GPIO_OUT_RST;
            mask[p] <= `GPIO_MASK_RST;
         end
         rise_en[0] <= 32'h00000000;
         rise_en[1] <= 32'h00000000;
         fall_en[0] <= 32'h00000000;
         fall_en[1] <= 32'h00000000;
         int_clr[0] <= 32'h00000000;
         int_clr[1] <= 32'h00000000;
         lb_rdata <= 32'h00000000;
         leg_rdata <= 32'h00000000;
         lb_ack <= 1'b0;
         leg_ack <= 1'b0;
         edge_irq <= 1'b0;
      end else if (ce) begin
         // Clear strobes to the catchers last one cycle only
         int_clr[0] <= 32'h00000000;
         int_clr[1] <= 32'h00000000;
         lb_ack <= lb_sel;
         leg_ack <= leg_sel && !lb_sel;
         if (lb_sel)
            lb_rdata <= rd;
         if (leg_sel && !lb_sel)
            leg_rdata <= rd;
         if (acc && acc_wr && port_ok) begin
            case (acc_idx)
               `GPIO_IDX_DIR: dir[acc_port] <= merge(dir[acc_port], acc_wd, acc_en);
               `GPIO_IDX_MASK: mask[acc_port] <= merge(mask[acc_port], acc_wd, acc_en);
               `GPIO_IDX_PIN: outl[acc_port] <= merge(outl[acc_port], acc_wd, wen);
               `GPIO_IDX_SET: outl[acc_port] <= outl[acc_port] | (acc_wd & wen);
               `GPIO_IDX_CLR: outl[acc_port] <= outl[acc_port] & ~(acc_wd & wen);
               `GPIO_IDX_OUT: outl[acc_port] <= merge(outl[acc_port], acc_wd, wen);
               default: outl[acc_port] <= outl[acc_port];
            endcase
         end
         if (acc && acc_wr && edge_ok) begin
            case (acc_idx)
               `GPIO_IDX_RISE_EN: rise_en[eport] <= merge(rise_en[eport], acc_wd, acc_en);
               `GPIO_IDX_FALL_EN: fall_en[eport] <= merge(fall_en[eport], acc_wd, acc_en);
               `GPIO_IDX_INT_CLR: int_clr[eport] <= acc_wd & acc_en;
               default: int_clr[eport] <= 32'h00000000;
            endcase
         end
         edge_irq <= |st_s2;
      end
   end

   // --------------------------------------------------------------
   // Two-stage synchronisers for pins and edge status
   // --------------------------------------------------------------
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1 <= 160'h0;
         pin_s2 <= 160'h0;
         st_s1 <= 128'h0;
         st_s2 <= 128'h0;
      end else if (ce) begin
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
         st_s1 <= st_raw;
         st_s2 <= st_s1;
      end
   end

   // --------------------------------------------------------------
   // Pin drivers, one clock behind the latch and direction registers
   // --------------------------------------------------------------
   integer q;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pin_out <= 160'h0;
         pin_oe <= 160'h0;
      end else if (ce) begin
         for (q = 0; q < 5; q = q + 1) begin
            pin_out[q*32 +: 32] <= outl[q];
            pin_oe[q*32 +: 32] <= dir[q];
         end
      end
   end

   // --------------------------------------------------------------
   // Wake request
   // --------------------------------------------------------------
   // Set straight from the raw catchers so it rises with every clock stopped;
   // it falls on the first enabled clock after all status has been cleared.
   wire raw_any = |st_raw;
   always @(posedge mclk or negedge rst_b or posedge raw_any) begin
      if (!rst_b)
         wake <= 1'b0;
      else if (raw_any)
         wake <= 1'b1;
      else if (ce)
         wake <= 1'b0;
   end
endmodule
